// ===== verilog/frc_pkg.sv
// constants for the ramp configuration register block
`default_nettype none
package frc_pkg;
  // register select codes carried in the low five bits of each word
  localparam logic [4:0] SEL_CLKDIV = 5'h0D;
  localparam logic [4:0] SEL_DEV = 5'h0E;
  localparam logic [4:0] SEL_STEP = 5'h0F;
  localparam logic [4:0] SEL_DELAY = 5'h10;
  localparam logic [4:0] SEL_RSVD = 5'h11;
  localparam logic [31:0] RSVD_VALUE = 32'h0000_0011;
  // field positions
  localparam int CLK2_LSB = 7;
  localparam int CLK2_W = 12;
  localparam int CSEL_LSB = 5;
  localparam int DEV_INV_BIT = 31;
  localparam int DEV_EXTCLK_BIT = 30;
  localparam int DSEL_LSB = 25;
  localparam int SHIFT_LSB = 21;
  localparam int SHIFT_W = 4;
  localparam int DEV_LSB = 5;
  localparam int DEV_W = 16;
  localparam int SSEL_LSB = 25;
  localparam int STEP_LSB = 3;
  localparam int STEP_W = 20;
  localparam int YSEL_LSB = 23;
  localparam int TRIG_EN_BIT = 20;
  localparam int DLY_EN_BIT = 19;
  localparam int DLY_LSB = 5;
  localparam int DLY_W = 12;
  localparam int SERIAL_W = 32;
  localparam int NSEG = 4;
  localparam int ACC_W = 48;
  // reset values
  localparam logic [11:0] CLK2_RST = 12'h001;
  localparam logic [11:0] CLK1_RST = 12'h001;
  typedef enum logic [1:0] {
    FRC_IDLE = 2'b00,
    FRC_DELAY = 2'b01,
    FRC_SLOPE = 2'b10
  } frc_state_t;
endpackage
`default_nettype wire

// ===== verilog/frc_trig_edge.sv
// trigger pin edge detector with selectable polarity
`timescale 1ns/100ps
`default_nettype none
module frc_trig_edge (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin,
  input wire logic invert,
  output logic active_edge
);
  logic pin_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end
  // rising edge normally, falling edge when inverted
  assign active_edge = invert ? (pin_q & ~pin) : (~pin_q & pin);
endmodule
`default_nettype wire

// ===== verilog/frc_ramp_regs.sv
// ramp configuration registers and a step sequencer using them
// **************************************************************
// **************************************************************
`timescale 1ns/100ps
`default_nettype none
module frc_ramp_regs #(
  parameter int ACC_W = frc_pkg::ACC_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_valid,
  input wire logic [31:0] wr_data,
  input wire logic [11:0] clk1_div,
  input wire logic ramp_enable,
  input wire logic continuous,
  input wire logic trig_pin,
  output logic [ACC_W-1:0] freq_offset_q,
  output logic ramping_q,
  output logic [1:0] segment_q,
  output logic step_pulse_q,
  output logic rsvd_bad_q
);
  // a full deviation shifted fifteen places needs 31 bits; the rest is summing room
  if (ACC_W < 40) begin : g_acc_w_check
    $error("accumulator too narrow");
  end
  // **************************************************************
  // register file
  // **************************************************************
  logic [11:0] clk2_q [frc_pkg::NSEG];
  logic [15:0] dev_q [frc_pkg::NSEG];
  logic [3:0] shift_q [frc_pkg::NSEG];
  logic [19:0] steps_q [frc_pkg::NSEG];
  logic [11:0] dly_q [frc_pkg::NSEG];
  logic trig_inv_q, ext_clk_q, trig_en_q, dly_en_q;
  logic [4:0] sel;
  assign sel = wr_data[4:0];

  function automatic logic [1:0] seg_of(input logic [31:0] w, input int lsb);
    seg_of = w[lsb +: 2];
  endfunction

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < frc_pkg::NSEG; i++) begin
        clk2_q[i] <= frc_pkg::CLK2_RST;
        dev_q[i] <= 16'h0000;
        shift_q[i] <= 4'h0;
        steps_q[i] <= 20'h00000;
        dly_q[i] <= 12'h000;
      end
      trig_inv_q <= 1'b0;
      ext_clk_q <= 1'b0;
      trig_en_q <= 1'b0;
      dly_en_q <= 1'b0;
    end else if (wr_valid) begin
      case (sel)
        frc_pkg::SEL_CLKDIV: begin
          clk2_q[seg_of(wr_data, frc_pkg::CSEL_LSB)] <= wr_data[18:7];
        end
        frc_pkg::SEL_DEV: begin
          trig_inv_q <= wr_data[frc_pkg::DEV_INV_BIT];
          ext_clk_q <= wr_data[frc_pkg::DEV_EXTCLK_BIT];
          dev_q[seg_of(wr_data, frc_pkg::DSEL_LSB)] <= wr_data[20:5];
          shift_q[seg_of(wr_data, frc_pkg::DSEL_LSB)] <= wr_data[24:21];
        end
        frc_pkg::SEL_STEP: begin
          steps_q[seg_of(wr_data, frc_pkg::SSEL_LSB)] <= wr_data[22:3];
        end
        frc_pkg::SEL_DELAY: begin
          trig_en_q <= wr_data[frc_pkg::TRIG_EN_BIT];
          dly_en_q <= wr_data[frc_pkg::DLY_EN_BIT];
          dly_q[seg_of(wr_data, frc_pkg::YSEL_LSB)] <= wr_data[16:5];
        end
        default: begin
        end
      endcase
    end
  end

  // reserved word checking: flags any deviating content
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsvd_bad_q <= 1'b0;
    end else if (wr_valid && sel == frc_pkg::SEL_RSVD) begin
      rsvd_bad_q <= (wr_data != frc_pkg::RSVD_VALUE);
    end
  end

  // **************************************************************
  // trigger and step timing
  // **************************************************************
  logic trig_edge;
  frc_trig_edge u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .pin(trig_pin),
    .invert(trig_inv_q),
    .active_edge(trig_edge)
  );

  frc_pkg::frc_state_t state_q;
  logic [23:0] tick_q;
  logic [23:0] tick_len;
  logic [19:0] step_cnt_q;
  logic [11:0] dly_cnt_q;
  logic step_now;
  logic last_step;
  logic run_q;

  // step lasts clk1 * clk2 clock periods; a zero in either divider gives a one-period step
  assign tick_len = 24'(clk1_div) * 24'(clk2_q[segment_q]);
  assign step_now = (state_q == frc_pkg::FRC_SLOPE) &&
                    (ext_clk_q ? trig_edge : (tick_q + 24'h1 >= tick_len));
  assign last_step = (step_cnt_q + 20'h1 >= steps_q[segment_q]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_q <= 24'h0;
    end else if (state_q != frc_pkg::FRC_SLOPE || step_now) begin
      tick_q <= 24'h0;
    end else begin
      tick_q <= tick_q + 24'h1;
    end
  end

  // run request: trigger pin gates start with enable; with the trigger enabled, continuous ramps
  // only start and stop on a trigger edge, which loads the enable level
  logic start_ok;
  assign start_ok = trig_en_q ? (ramp_enable && trig_pin) : ramp_enable;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 1'b0;
    end else if (continuous && trig_en_q) begin
      if (trig_edge) begin
        run_q <= ramp_enable;
      end
    end else begin
      run_q <= start_ok;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= frc_pkg::FRC_IDLE;
      segment_q <= 2'b00;
      step_cnt_q <= 20'h0;
      dly_cnt_q <= 12'h0;
    end else begin
      case (state_q)
        frc_pkg::FRC_IDLE: begin
          segment_q <= 2'b00;
          step_cnt_q <= 20'h0;
          dly_cnt_q <= 12'h0;
          if (run_q) begin
            state_q <= dly_en_q ? frc_pkg::FRC_DELAY : frc_pkg::FRC_SLOPE;
          end
        end
        frc_pkg::FRC_DELAY: begin
          if (!run_q) begin
            state_q <= frc_pkg::FRC_IDLE;
          end else if (dly_cnt_q + 12'h1 >= dly_q[segment_q]) begin
            dly_cnt_q <= 12'h0;
            state_q <= frc_pkg::FRC_SLOPE;
          end else begin
            dly_cnt_q <= dly_cnt_q + 12'h1;
          end
        end
        frc_pkg::FRC_SLOPE: begin
          if (!run_q) begin
            state_q <= frc_pkg::FRC_IDLE;
          end else if (step_now) begin
            if (last_step) begin
              step_cnt_q <= 20'h0;
              segment_q <= segment_q + 2'b01;
              state_q <= dly_en_q ? frc_pkg::FRC_DELAY : frc_pkg::FRC_SLOPE;
            end else begin
              step_cnt_q <= step_cnt_q + 20'h1;
            end
          end
        end
        default: begin
          state_q <= frc_pkg::FRC_IDLE;
        end
      endcase
    end
  end

  // **************************************************************
  // frequency accumulator
  // **************************************************************
  logic [ACC_W-1:0] dev_scaled;
  // sign extension keeps negative words as downward slopes
  assign dev_scaled = ACC_W'($signed(dev_q[segment_q])) << shift_q[segment_q];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      freq_offset_q <= '0;
      step_pulse_q <= 1'b0;
      ramping_q <= 1'b0;
    end else begin
      step_pulse_q <= step_now;
      ramping_q <= (state_q != frc_pkg::FRC_IDLE);
      if (state_q == frc_pkg::FRC_IDLE) begin
        freq_offset_q <= '0;
      end else if (step_now) begin
        freq_offset_q <= freq_offset_q + dev_scaled;
      end
    end
  end

  // **************************************************************
  // checks
  // **************************************************************
  dev_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_valid && sel == frc_pkg::SEL_DEV) |=> (ext_clk_q == $past(wr_data[30])))
    else $error("external clock select not loaded");
  inv_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_valid && sel == frc_pkg::SEL_DEV) |=> (trig_inv_q == $past(wr_data[31])))
    else $error("trigger invert not loaded");
  step_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_valid && sel == frc_pkg::SEL_STEP) |=>
      (steps_q[$past(wr_data[26:25])] == $past(wr_data[22:3])))
    else $error("step count not loaded");
  dly_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_valid && sel == frc_pkg::SEL_DELAY) |=>
      (dly_q[$past(wr_data[24:23])] == $past(wr_data[16:5])))
    else $error("delay word not loaded");
  clk2_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_valid && sel == frc_pkg::SEL_CLKDIV) |=>
      (clk2_q[$past(wr_data[6:5])] == $past(wr_data[18:7])))
    else $error("divider word not loaded");
  idle_flat_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == frc_pkg::FRC_IDLE) |=> (freq_offset_q == '0))
    else $error("offset moved while idle");
  accum_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (step_now && run_q) |=> (freq_offset_q == $past(freq_offset_q) + $past(dev_scaled)))
    else $error("step did not add deviation");
  trig_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (trig_en_q && !continuous && !trig_pin) |=> !run_q)
    else $error("ramp ran without trigger level");
  no_delay_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == frc_pkg::FRC_IDLE && run_q && !dly_en_q) |=> (state_q == frc_pkg::FRC_SLOPE))
    else $error("delay inserted while disabled");
  cont_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    (continuous && trig_en_q && !trig_edge) |=> (run_q == $past(run_q)))
    else $error("continuous ramp changed without trigger");
  cont_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
    (continuous && trig_en_q && trig_edge) |=> (run_q == $past(ramp_enable)))
    else $error("trigger did not apply the enable level");
  // a delayed start walks idle, then delay with a cleared count, then slope
  sequence frc_start_delayed_s;
    state_q == frc_pkg::FRC_IDLE && run_q && dly_en_q;
  endsequence
  sequence frc_delay_fresh_s;
    state_q == frc_pkg::FRC_DELAY && dly_cnt_q == 12'h000;
  endsequence
  sequence frc_delay_done_s;
    state_q == frc_pkg::FRC_DELAY && run_q && (dly_cnt_q + 12'h1 >= dly_q[segment_q]);
  endsequence
  delay_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
    frc_start_delayed_s |=> frc_delay_fresh_s)
    else $error("delay not entered with a cleared count");
  delay_exit_a: assert property (@(posedge clk) disable iff (!arst_n)
    frc_delay_done_s |=> (state_q == frc_pkg::FRC_SLOPE))
    else $error("delay did not end into a slope");
  seg_adv_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == frc_pkg::FRC_SLOPE && run_q && step_now && last_step) |=>
      (segment_q == $past(segment_q) + 2'b01))
    else $error("segment did not advance");
  seg_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == frc_pkg::FRC_IDLE) |=> (segment_q == 2'b00))
    else $error("segment not rewound while idle");
  ext_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == frc_pkg::FRC_SLOPE && ext_clk_q && trig_edge) |=> step_pulse_q)
    else $error("trigger edge did not step");
  rsvd_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_valid && sel == frc_pkg::SEL_RSVD) |=>
      (rsvd_bad_q == ($past(wr_data) != frc_pkg::RSVD_VALUE)))
    else $error("reserved word check wrong");
endmodule
`default_nettype wire

// ===== tb/frc_host_model.sv
// host controller model that writes ramp configuration words
`timescale 1ns/100ps
`default_nettype none
module frc_host_model #(
  // calibration wait in clocks: 1200 us at 8 ns per clock
  parameter int CAL_WAIT_CYC = 150000
) (
  input wire logic clk,
  output logic wr_valid,
  output logic [31:0] wr_data
);
  initial begin
    wr_valid = 1'b0;
    wr_data = 32'h0000_0000;
  end
  // **********************************
  // write access
  // **********************************
  // released data lines show the inverse word, so a stale value never looks valid
  task automatic send(input logic [31:0] w);
    @(posedge clk);
    #1;
    wr_valid = 1'b1;
    wr_data = w;
    @(posedge clk);
    #1;
    wr_valid = 1'b0;
    wr_data = ~w;
  endtask
  task automatic init();
    send(frc_pkg::RSVD_VALUE);
  endtask
  // a recalibration starts with the calibration wait, then the fixed word is rewritten
  task automatic recal();
    repeat (CAL_WAIT_CYC) @(posedge clk);
    init();
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_frc_ramp_regs.sv
// self-checking bench for the ramp configuration registers
`timescale 1ns/100ps
`default_nettype none
module tb_frc_ramp_regs;
  logic clk, arst_n, wr_valid, ramp_enable, continuous, trig_pin;
  logic ramping_q, step_pulse_q, rsvd_bad_q;
  logic [31:0] wr_data;
  logic [11:0] clk1_div;
  logic [1:0] segment_q;
  logic [frc_pkg::ACC_W-1:0] freq_offset_q, exp_off;
  logic [15:0] devs [4] = '{16'h0005, 16'hFFFD, 16'h0005, 16'hFFFD};
  logic [3:0] shifts [4] = '{4'h1, 4'h2, 4'h1, 4'h2};
  logic [11:0] clk2s [4] = '{12'h002, 12'h004, 12'h002, 12'h004};
  int failures, n_tests, cyc;
  frc_ramp_regs i_frc_ramp_regs (.clk(clk), .arst_n(arst_n), .wr_valid(wr_valid),
    .wr_data(wr_data), .clk1_div(clk1_div), .ramp_enable(ramp_enable),
    .continuous(continuous), .trig_pin(trig_pin), .freq_offset_q(freq_offset_q),
    .ramping_q(ramping_q), .segment_q(segment_q), .step_pulse_q(step_pulse_q),
    .rsvd_bad_q(rsvd_bad_q));
  // calibration wait shortened: the block under test never observes it
  frc_host_model #(.CAL_WAIT_CYC(40)) i_frc_host_model (.clk(clk), .wr_valid(wr_valid),
    .wr_data(wr_data));
  always #4 clk = ~clk;
  // **********************************
  // helpers
  // **********************************
  function automatic logic [31:0] dlyw(input logic [1:0] s, input logic tr, input logic de,
                                       input logic [11:0] d);
    return {7'h00, s, 2'b00, tr, de, 2'b00, d, frc_pkg::SEL_DELAY};
  endfunction
  function automatic logic [31:0] devw(input logic inv, input logic ext, input logic [1:0] s,
                                       input logic [3:0] sh, input logic [15:0] d);
    return {inv, ext, 3'b000, s, sh, d, frc_pkg::SEL_DEV};
  endfunction
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // returns edges until a step pulse, or lim when none came
  task automatic wait_pulse(input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (step_pulse_q !== 1'b1 && c < lim);
  endtask
  // holds the pin four clocks; the edge detector needs it high at only one clock edge
  task automatic pulse_trig();
    trig_pin = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    trig_pin = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // **********************************
  // tests
  // **********************************
  // the whole run needs a few hundred cycles; this span leaves a wide margin
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    ramp_enable = 1'b0;
    continuous = 1'b0;
    trig_pin = 1'b0;
    clk1_div = 12'h003;
    failures = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    #1;
    check("reset outputs", {freq_offset_q, ramping_q, segment_q, step_pulse_q, rsvd_bad_q},
      0);
    arst_n = 1'b1;
    i_frc_host_model.init();
    check("reserved flag", rsvd_bad_q, 0);
    for (int s = 0; s < 4; s++) i_frc_host_model.send(dlyw(2'(s), 1'b0, 1'b0, 12'h000));
    // step field sits on bits 22:3, so the low two count bits come from the select code
    for (int s = 0; s < 4; s++) i_frc_host_model.send({5'h00, 2'(s), 2'b00, 18'h00001,
      frc_pkg::SEL_STEP});
    for (int s = 0; s < 4; s++) i_frc_host_model.send(devw(1'b0, 1'b0, 2'(s), shifts[s],
      devs[s]));
    for (int s = 0; s < 4; s++) i_frc_host_model.send({13'h0000, clk2s[s], 2'(s),
      frc_pkg::SEL_CLKDIV});
    ramp_enable = 1'b1;
    exp_off = '0;
    for (int k = 0; k < 7; k++) begin
      wait_pulse(500, cyc);
      exp_off = exp_off + ({{(frc_pkg::ACC_W-16){devs[k/5][15]}}, devs[k/5]} << shifts[k/5]);
      check("offset", freq_offset_q, exp_off);
      if (k > 0 && k < 5) check("step time", cyc, 6);
      if (k == 3) check("segment", segment_q, 0);
      if (k == 6) check("segment", segment_q, 1);
      if (k == 6) check("step time", cyc, 12);
    end
    ramp_enable = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("ramping", ramping_q, 0);
    $display("test ramp done");
    for (int s = 0; s < 4; s++) i_frc_host_model.send(dlyw(2'(s), 1'b1, 1'b1, 12'h014));
    ramp_enable = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check("ramping", ramping_q, 0);
    trig_pin = 1'b1;
    wait_pulse(500, cyc);
    check("delayed start", cyc >= 26, 1);
    check("ramping", ramping_q, 1);
    ramp_enable = 1'b0;
    trig_pin = 1'b0;
    $display("test trigger done");
    for (int s = 0; s < 4; s++) i_frc_host_model.send(dlyw(2'(s), 1'b0, 1'b0, 12'h000));
    i_frc_host_model.send(devw(1'b1, 1'b1, 2'b00, shifts[0], devs[0]));
    ramp_enable = 1'b1;
    trig_pin = 1'b1;
    wait_pulse(12, cyc);
    check("rising edge step", cyc < 12, 0);
    trig_pin = 1'b0;
    wait_pulse(8, cyc);
    check("falling edge step", cyc < 8, 1);
    ramp_enable = 1'b0;
    $display("test external clock done");
    // continuous mode with the trigger enabled: the enable level alone neither starts nor stops the ramp
    for (int s = 0; s < 4; s++) i_frc_host_model.send(dlyw(2'(s), 1'b1, 1'b0, 12'h000));
    i_frc_host_model.send(devw(1'b0, 1'b0, 2'b00, shifts[0], devs[0]));
    continuous = 1'b1;
    ramp_enable = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("continuous idle", ramping_q, 0);
    pulse_trig();
    check("continuous start", ramping_q, 1);
    ramp_enable = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("continuous hold", ramping_q, 1);
    pulse_trig();
    check("continuous stop", ramping_q, 0);
    continuous = 1'b0;
    $display("test continuous done");
    i_frc_host_model.send(32'h0000_0111);
    check("reserved flag", rsvd_bad_q, 1);
    i_frc_host_model.recal();
    check("reserved flag", rsvd_bad_q, 0);
    $display("test reserved done");
    report_and_stop();
  end
endmodule
`default_nettype wire
